// ### hdl/lpw_pkg.sv
package lpw_pkg;

    // ------------------------------------------------------------------
    // Register offsets
    // ------------------------------------------------------------------
    localparam logic [7:0] LPW_OFF_CONTROL = 8'h00;
    localparam logic [7:0] LPW_OFF_P0_STATUS = 8'h04;
    localparam logic [7:0] LPW_OFF_P0_ENABLE = 8'h08;
    localparam logic [7:0] LPW_OFF_P1_STATUS = 8'h0c;
    localparam logic [7:0] LPW_OFF_P1_ENABLE = 8'h10;
    localparam logic [7:0] LPW_OFF_P2_STATUS = 8'h14;
    localparam logic [7:0] LPW_OFF_P2_ENABLE = 8'h18;
    localparam logic [7:0] LPW_OFF_P3_STATUS = 8'h1c;
    localparam logic [7:0] LPW_OFF_P3_ENABLE = 8'h20;
    localparam logic [7:0] LPW_OFF_PERIPH_STATUS = 8'h30;
    localparam logic [7:0] LPW_OFF_IRQ_MASK = 8'h40;
    localparam logic [7:0] LPW_OFF_PM_CONTROL = 8'h44;

    // ------------------------------------------------------------------
    // Control word fields
    // ------------------------------------------------------------------
    localparam int LPW_BIT_STATUS_CLEAR = 31;
    localparam int LPW_BIT_BANDGAP_OFF = 11;
    localparam int LPW_BIT_ENTRY_CLOCK = 9;
    localparam int LPW_BIT_LPM_CLOCK = 8;
    localparam logic [31:0] LPW_CONTROL_RESET = 32'h0000_0900;
    localparam logic [31:0] LPW_CONTROL_WMASK = 32'h7fff_fbff;

    // ------------------------------------------------------------------
    // Port widths and pin masks
    // ------------------------------------------------------------------
    localparam int LPW_P0_PINS = 32;
    localparam int LPW_P1_PINS = 10;
    localparam int LPW_P2_PINS = 8;
    localparam int LPW_P3_PINS = 2;
    localparam logic [31:0] LPW_P0_MASK = 32'hffff_ffff;
    localparam logic [31:0] LPW_P1_MASK = 32'h0000_03ff;
    localparam logic [31:0] LPW_P2_MASK = 32'h0000_00ff;
    localparam logic [31:0] LPW_P3_MASK = 32'h0000_0003;
    localparam logic [31:0] LPW_PERIPH_MASK = 32'h0003_0010;
    localparam logic [3:0] LPW_IRQ_MASK_BITS = 4'hf;

    // ------------------------------------------------------------------
    // Bus answers
    // ------------------------------------------------------------------
    localparam logic [1:0] LPW_RESP_OKAY = 2'h0;
    localparam logic [1:0] LPW_RESP_SLVERR = 2'h2;

endpackage : lpw_pkg

// ### hdl/lpw_edge_detect.sv
`timescale 1ns/10ps

// Two-flop synchroniser per pin followed by a toggle detector on the
// synchronised level.
module lpw_edge_detect #(
    parameter int WIDTH = 32
) (
    // Clock and reset.
    input wire logic aclk,
    input wire logic aresetn,
    // Pins and detected edges.
    input wire logic [WIDTH-1:0] pin_in,
    output logic [WIDTH-1:0] pin_edge
);

    typedef struct packed {
        logic [WIDTH-1:0] meta;
        logic [WIDTH-1:0] sync;
        logic [WIDTH-1:0] last;
        logic [WIDTH-1:0] edge_seen;
        logic [2:0] primed;
    } lpw_edge_state_type;

    lpw_edge_state_type state_ff;
    lpw_edge_state_type nxt_state;

    always_comb begin
        nxt_state = state_ff;
        nxt_state.meta = pin_in;
        nxt_state.sync = state_ff.meta;
        nxt_state.last = state_ff.sync;
        nxt_state.primed = {state_ff.primed[1:0], 1'b1};
        // Both directions count; compares wait until every stage holds a pin sample taken after reset.
        nxt_state.edge_seen = state_ff.primed[2] ? (state_ff.sync ^ state_ff.last) : '0;
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state_ff <= '0;
        end else begin
            state_ff <= nxt_state;
        end
    end

    assign pin_edge = state_ff.edge_seen;

endmodule // lpw_edge_detect

// ### hdl/lpw_wakeup_control.sv
`timescale 1ns/10ps

module lpw_wakeup_control (
    // Clock and reset.
    input wire logic aclk,
    input wire logic aresetn,
    // Write address channel.
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    // Write data channel.
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    // Write response channel.
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // Read address channel.
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    // Read data channel.
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // GPIO pins.
    input wire logic [lpw_pkg::LPW_P0_PINS-1:0] port0_pins,
    input wire logic [lpw_pkg::LPW_P1_PINS-1:0] port1_pins,
    input wire logic [lpw_pkg::LPW_P2_PINS-1:0] port2_pins,
    input wire logic [lpw_pkg::LPW_P3_PINS-1:0] port3_pins,
    // Peripheral wake events, one pulse per cause.
    input wire logic [31:0] periph_wake_event,
    // Power-mode control.
    input wire logic in_low_power_mode,
    output logic wake_to_active,
    output logic bandgap_off_in_sleep,
    output logic entry_clock_select,
    output logic lpm_clock_select,
    output logic [3:0] ram_bank_retain,
    output logic global_gpio_wake_enable,
    // Interrupt.
    output logic wake_irq
);

    import lpw_pkg::*;

    typedef struct packed {
        logic aw_held;
        logic [7:0] aw_addr;
        logic w_held;
        logic [31:0] w_data;
        logic [3:0] w_strb;
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
        logic [31:0] control;
        logic [31:0] st0;
        logic [31:0] en0;
        logic [31:0] st1;
        logic [31:0] en1;
        logic [31:0] st2;
        logic [31:0] en2;
        logic [31:0] st3;
        logic [31:0] en3;
        logic [31:0] pst;
        logic [3:0] irq_mask;
        logic gpio_we;
        logic wake;
        logic irq;
        logic aw_ready;
        logic w_ready;
        logic ar_ready;
    } lpw_state_type;

    lpw_state_type state_ff;
    lpw_state_type nxt_state;

    logic [31:0] edge0;
    logic [31:0] edge1;
    logic [31:0] edge2;
    logic [31:0] edge3;
    logic [LPW_P1_PINS-1:0] edge1_raw;
    logic [LPW_P2_PINS-1:0] edge2_raw;
    logic [LPW_P3_PINS-1:0] edge3_raw;

    // ------------------------------------------------------------------
    // Pin edge detection
    // ------------------------------------------------------------------
    lpw_edge_detect #(.WIDTH(LPW_P0_PINS)) u_edge0 (
        .aclk(aclk),
        .aresetn(aresetn),
        .pin_in(port0_pins),
        .pin_edge(edge0)
    );
    lpw_edge_detect #(.WIDTH(LPW_P1_PINS)) u_edge1 (
        .aclk(aclk),
        .aresetn(aresetn),
        .pin_in(port1_pins),
        .pin_edge(edge1_raw)
    );
    lpw_edge_detect #(.WIDTH(LPW_P2_PINS)) u_edge2 (
        .aclk(aclk),
        .aresetn(aresetn),
        .pin_in(port2_pins),
        .pin_edge(edge2_raw)
    );
    lpw_edge_detect #(.WIDTH(LPW_P3_PINS)) u_edge3 (
        .aclk(aclk),
        .aresetn(aresetn),
        .pin_in(port3_pins),
        .pin_edge(edge3_raw)
    );

    assign edge1 = {22'h0, edge1_raw};
    assign edge2 = {24'h0, edge2_raw};
    assign edge3 = {30'h0, edge3_raw};

    // ------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------
    function automatic logic [31:0] strb_mask(input logic [3:0] strb);
        strb_mask = {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}};
    endfunction

    // Sticky update: a new event wins over a write-one-to-clear.
    function automatic logic [31:0] sticky(input logic [31:0] cur, input logic [31:0] set_bits,
                                           input logic [31:0] clr_bits, input logic [31:0] mask);
        sticky = ((cur & ~clr_bits) | set_bits) & mask;
    endfunction

    function automatic logic addr_known(input logic [7:0] a);
        case (a)
            LPW_OFF_CONTROL, LPW_OFF_P0_STATUS, LPW_OFF_P0_ENABLE, LPW_OFF_P1_STATUS,
            LPW_OFF_P1_ENABLE, LPW_OFF_P2_STATUS, LPW_OFF_P2_ENABLE, LPW_OFF_P3_STATUS,
            LPW_OFF_P3_ENABLE, LPW_OFF_PERIPH_STATUS, LPW_OFF_IRQ_MASK,
            LPW_OFF_PM_CONTROL: addr_known = 1'b1;
            default: addr_known = 1'b0;
        endcase
    endfunction

    // ------------------------------------------------------------------
    // Next-state logic
    // ------------------------------------------------------------------
    always_comb begin
        logic do_write;
        logic [31:0] wm;
        logic [31:0] wd;
        logic [31:0] clr0;
        logic [31:0] clr1;
        logic [31:0] clr2;
        logic [31:0] clr3;
        logic [31:0] clrp;
        logic bulk;
        logic [3:0] pend;
        do_write = 1'b0;
        wm = '0;
        wd = '0;
        clr0 = '0;
        clr1 = '0;
        clr2 = '0;
        clr3 = '0;
        clrp = '0;
        bulk = 1'b0;
        pend = '0;
        nxt_state = state_ff;

        // Address and data are taken in either order and held until both exist.
        if (s_axi_awvalid && !state_ff.aw_held) begin
            nxt_state.aw_held = 1'b1;
            nxt_state.aw_addr = s_axi_awaddr;
        end
        if (s_axi_wvalid && !state_ff.w_held) begin
            nxt_state.w_held = 1'b1;
            nxt_state.w_data = s_axi_wdata;
            nxt_state.w_strb = s_axi_wstrb;
        end
        if (state_ff.bvalid && s_axi_bready) begin
            nxt_state.bvalid = 1'b0;
        end

        if (state_ff.aw_held && state_ff.w_held && !state_ff.bvalid) begin
            do_write = 1'b1;
            wm = strb_mask(state_ff.w_strb);
            wd = state_ff.w_data & wm;
            nxt_state.aw_held = 1'b0;
            nxt_state.w_held = 1'b0;
            nxt_state.bvalid = 1'b1;
            nxt_state.bresp = addr_known(state_ff.aw_addr) ? LPW_RESP_OKAY : LPW_RESP_SLVERR;
        end

        // Bulk clear is acted on one cycle after it is written, then drops.
        bulk = state_ff.control[LPW_BIT_STATUS_CLEAR];
        if (bulk) begin
            clr0 = '1;
            clr1 = '1;
            clr2 = '1;
            clr3 = '1;
            clrp = '1;
            nxt_state.control[LPW_BIT_STATUS_CLEAR] = 1'b0;
        end

        if (do_write) begin
            case (state_ff.aw_addr)
                LPW_OFF_CONTROL: begin
                    // Bits 30:12 and 7:4 are stored as written; 10 reads zero.
                    nxt_state.control = ((state_ff.control & ~wm) | (wd & LPW_CONTROL_WMASK)) &
                                        LPW_CONTROL_WMASK;
                    if (wd[LPW_BIT_STATUS_CLEAR]) begin
                        nxt_state.control[LPW_BIT_STATUS_CLEAR] = 1'b1;
                    end
                end
                LPW_OFF_P0_STATUS: clr0 = clr0 | wd;
                LPW_OFF_P0_ENABLE: nxt_state.en0 = (state_ff.en0 & ~wm) | wd;
                LPW_OFF_P1_STATUS: clr1 = clr1 | wd;
                LPW_OFF_P1_ENABLE: nxt_state.en1 = ((state_ff.en1 & ~wm) | wd) & LPW_P1_MASK;
                LPW_OFF_P2_STATUS: clr2 = clr2 | wd;
                LPW_OFF_P2_ENABLE: nxt_state.en2 = ((state_ff.en2 & ~wm) | wd) & LPW_P2_MASK;
                LPW_OFF_P3_STATUS: clr3 = clr3 | wd;
                LPW_OFF_P3_ENABLE: nxt_state.en3 = ((state_ff.en3 & ~wm) | wd) & LPW_P3_MASK;
                LPW_OFF_PERIPH_STATUS: clrp = clrp | wd;
                LPW_OFF_IRQ_MASK: nxt_state.irq_mask = ((state_ff.irq_mask & ~wm[3:0]) | wd[3:0]) &
                                                       LPW_IRQ_MASK_BITS;
                LPW_OFF_PM_CONTROL: begin
                    if (wm[0]) begin
                        nxt_state.gpio_we = wd[0];
                    end
                end
                default: begin
                end
            endcase
        end

        // Edges set status in every power mode.
        nxt_state.st0 = sticky(state_ff.st0, edge0, clr0, LPW_P0_MASK);
        nxt_state.st1 = sticky(state_ff.st1, edge1, clr1, LPW_P1_MASK);
        nxt_state.st2 = sticky(state_ff.st2, edge2, clr2, LPW_P2_MASK);
        nxt_state.st3 = sticky(state_ff.st3, edge3, clr3, LPW_P3_MASK);
        nxt_state.pst = sticky(state_ff.pst, periph_wake_event & LPW_PERIPH_MASK, clrp, LPW_PERIPH_MASK);

        // Masks keep unimplemented bits out of the wake decision.
        pend[0] = |(state_ff.st0 & state_ff.en0 & LPW_P0_MASK);
        pend[1] = |(state_ff.st1 & state_ff.en1 & LPW_P1_MASK);
        pend[2] = |(state_ff.st2 & state_ff.en2 & LPW_P2_MASK);
        pend[3] = |(state_ff.st3 & state_ff.en3 & LPW_P3_MASK);
        pend = pend & {4{state_ff.gpio_we}};

        // Wake is a level; the power logic leaves low-power mode while it stands.
        nxt_state.wake = in_low_power_mode && (|pend);
        nxt_state.irq = |(pend & state_ff.irq_mask);

        // Read channel.
        if (state_ff.rvalid && s_axi_rready) begin
            nxt_state.rvalid = 1'b0;
        end
        if (s_axi_arvalid && !state_ff.rvalid) begin
            nxt_state.rvalid = 1'b1;
            nxt_state.rresp = addr_known(s_axi_araddr) ? LPW_RESP_OKAY : LPW_RESP_SLVERR;
            case (s_axi_araddr)
                LPW_OFF_CONTROL: nxt_state.rdata = state_ff.control;
                LPW_OFF_P0_STATUS: nxt_state.rdata = state_ff.st0;
                LPW_OFF_P0_ENABLE: nxt_state.rdata = state_ff.en0;
                LPW_OFF_P1_STATUS: nxt_state.rdata = state_ff.st1;
                LPW_OFF_P1_ENABLE: nxt_state.rdata = state_ff.en1;
                LPW_OFF_P2_STATUS: nxt_state.rdata = state_ff.st2;
                LPW_OFF_P2_ENABLE: nxt_state.rdata = state_ff.en2;
                LPW_OFF_P3_STATUS: nxt_state.rdata = state_ff.st3;
                LPW_OFF_P3_ENABLE: nxt_state.rdata = state_ff.en3;
                LPW_OFF_PERIPH_STATUS: nxt_state.rdata = state_ff.pst;
                LPW_OFF_IRQ_MASK: nxt_state.rdata = {28'h0, state_ff.irq_mask};
                LPW_OFF_PM_CONTROL: nxt_state.rdata = {31'h0, state_ff.gpio_we};
                default: nxt_state.rdata = '0;
            endcase
        end

        // Readies are flops of their own so that the bus sees no logic behind them.
        nxt_state.aw_ready = !nxt_state.aw_held;
        nxt_state.w_ready = !nxt_state.w_held;
        nxt_state.ar_ready = !nxt_state.rvalid;
    end

    // ------------------------------------------------------------------
    // State register
    // ------------------------------------------------------------------
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state_ff <= '0;
            state_ff.control <= LPW_CONTROL_RESET;
            // Readies stand high in reset so that a master may start at the first edge after release.
            state_ff.aw_ready <= 1'b1;
            state_ff.w_ready <= 1'b1;
            state_ff.ar_ready <= 1'b1;
        end else begin
            state_ff <= nxt_state;
        end
    end

    // ------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------
    assign s_axi_awready = state_ff.aw_ready;
    assign s_axi_wready = state_ff.w_ready;
    assign s_axi_bvalid = state_ff.bvalid;
    assign s_axi_bresp = state_ff.bresp;
    assign s_axi_arready = state_ff.ar_ready;
    assign s_axi_rvalid = state_ff.rvalid;
    assign s_axi_rdata = state_ff.rdata;
    assign s_axi_rresp = state_ff.rresp;
    assign wake_to_active = state_ff.wake;
    assign bandgap_off_in_sleep = state_ff.control[LPW_BIT_BANDGAP_OFF];
    assign entry_clock_select = state_ff.control[LPW_BIT_ENTRY_CLOCK];
    assign lpm_clock_select = state_ff.control[LPW_BIT_LPM_CLOCK];
    assign ram_bank_retain = state_ff.control[3:0];
    assign global_gpio_wake_enable = state_ff.gpio_we;
    assign wake_irq = state_ff.irq;

endmodule // lpw_wakeup_control

// ### verif/lpw_wakeup_assertions.sv
`timescale 1ns/10ps
module lpw_wakeup_checker (
    // Clock and reset.
    input wire logic aclk,
    input wire logic aresetn,
    // Bus handshakes.
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // Power-mode side.
    input wire logic in_low_power_mode,
    input wire logic wake_to_active,
    input wire logic bandgap_off_in_sleep,
    input wire logic entry_clock_select,
    input wire logic lpm_clock_select,
    input wire logic [3:0] ram_bank_retain,
    input wire logic global_gpio_wake_enable,
    input wire logic wake_irq
);
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    logic [6:0] ctrl_out;
    assign ctrl_out = {bandgap_off_in_sleep, entry_clock_select, lpm_clock_select, ram_bank_retain};
    a_ctrl_reset: assert property ($rose(aresetn) |-> ctrl_out == 7'h50)
        else $error("control outputs not at reset values");
    a_ctrl_by_write: assert property ($changed(ctrl_out) |-> $rose(s_axi_bvalid))
        else $error("control output changed without a write");
    a_wake_cause: assert property (wake_to_active |-> $past(in_low_power_mode) && $past(global_gpio_wake_enable))
        else $error("wake without low-power mode or global enable");
    a_wake_leaves: assert property (!in_low_power_mode |=> !wake_to_active)
        else $error("wake asserted outside low-power mode");
    a_irq_global: assert property (wake_irq |-> $past(global_gpio_wake_enable))
        else $error("wake interrupt without global enable");
    a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read not answered in one cycle");
    a_read_holds: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data dropped before taken");
    a_write_holds: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
        else $error("write response dropped before taken");
endmodule // lpw_wakeup_checker

bind lpw_wakeup_control lpw_wakeup_checker u_chk (.aclk, .aresetn, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .s_axi_bvalid, .s_axi_bready, .in_low_power_mode,
    .wake_to_active, .bandgap_off_in_sleep, .entry_clock_select, .lpm_clock_select, .ram_bank_retain,
    .global_gpio_wake_enable, .wake_irq);

// ### verif/lpw_pin_model.sv
`timescale 1ns/10ps
module lpw_pin_model (
    // Clock and reset.
    input wire logic aclk,
    input wire logic aresetn,
    // Power-mode handshake.
    input wire logic sleep_req,
    input wire logic wake_to_active,
    output logic in_low_power_mode,
    // GPIO pins.
    output logic [31:0] port0_pins,
    output logic [9:0] port1_pins,
    output logic [7:0] port2_pins,
    output logic [1:0] port3_pins
);
    initial begin
        {port0_pins, port1_pins, port2_pins, port3_pins} = '0;
        in_low_power_mode = 1'b0;
    end
    // The power logic returns to active on the first wake request.
    always @(posedge aclk) begin
        if (!aresetn)
            in_low_power_mode <= 1'b0;
        else if (wake_to_active)
            in_low_power_mode <= 1'b0;
        else if (sleep_req)
            in_low_power_mode <= 1'b1;
    end
    task automatic flip(input int p, input int b);
        @(posedge aclk);
        case (p)
            0: port0_pins[b] <= ~port0_pins[b];
            1: port1_pins[b] <= ~port1_pins[b];
            2: port2_pins[b] <= ~port2_pins[b];
            default: port3_pins[b] <= ~port3_pins[b];
        endcase
    endtask
endmodule // lpw_pin_model

// ### verif/tb.sv
`timescale 1ns/10ps
module tb;
    import lpw_pkg::*;
    typedef struct packed {
        logic wr;
        logic [7:0] addr;
        logic [31:0] data;
        logic [31:0] exp;
        logic [1:0] resp;
        logic [6:0] outs;
    } lpw_row_type;
    logic aclk = 1'b0, aresetn = 1'b0, sleep_req = 1'b0;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
    logic [31:0] s_axi_wdata = 32'h0, periph_wake_event = 32'h0;
    logic [3:0] s_axi_wstrb = 4'hf;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp, resp_got;
    logic [31:0] s_axi_rdata, port0_pins, rdata_got;
    logic [9:0] port1_pins;
    logic [7:0] port2_pins;
    logic [1:0] port3_pins;
    logic in_low_power_mode, wake_to_active, bandgap_off_in_sleep, entry_clock_select;
    logic lpm_clock_select, global_gpio_wake_enable, wake_irq;
    logic [3:0] ram_bank_retain;
    logic [6:0] outs;
    int fails = 0, checked = 0, cyc = 0;
    logic [7:0] clr_list [5] = '{8'h04, 8'h0c, 8'h14, 8'h1c, 8'h30};
    lpw_row_type rows [11] = '{
        '{1'b0, 8'h00, 32'h0, 32'h0000_0900, 2'h0, 7'h50},
        '{1'b0, 8'h04, 32'h0, 32'h0, 2'h0, 7'h50},
        '{1'b1, 8'h08, 32'hffff_ffff, 32'hffff_ffff, 2'h0, 7'h50},
        '{1'b1, 8'h10, 32'hffff_ffff, 32'h0000_03ff, 2'h0, 7'h50},
        '{1'b1, 8'h0c, 32'hffff_ffff, 32'h0, 2'h0, 7'h50},
        '{1'b1, 8'h18, 32'hffff_ffff, 32'h0000_00ff, 2'h0, 7'h50},
        '{1'b1, 8'h20, 32'hffff_ffff, 32'h0000_0003, 2'h0, 7'h50},
        '{1'b1, 8'h00, 32'h0000_0b0f, 32'h0000_0b0f, 2'h0, 7'h7f},
        '{1'b1, 8'h00, 32'h0000_0405, 32'h0000_0005, 2'h0, 7'h05},
        '{1'b1, 8'h2c, 32'h1, 32'h0, 2'h2, 7'h05},
        '{1'b1, 8'h40, 32'hf, 32'hf, 2'h0, 7'h05}};
    assign outs = {bandgap_off_in_sleep, entry_clock_select, lpm_clock_select, ram_bank_retain};

    lpw_wakeup_control dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
        .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
        .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .port0_pins,
        .port1_pins, .port2_pins, .port3_pins, .periph_wake_event, .in_low_power_mode, .wake_to_active,
        .bandgap_off_in_sleep, .entry_clock_select, .lpm_clock_select, .ram_bank_retain,
        .global_gpio_wake_enable, .wake_irq);
    lpw_pin_model model (.aclk, .aresetn, .sleep_req, .wake_to_active, .in_low_power_mode, .port0_pins,
        .port1_pins, .port2_pins, .port3_pins);

    // --------
    // Helpers
    // --------
    always #20 aclk = ~aclk;
    always @(posedge aclk) begin
        cyc++;
        if (cyc == 3000) begin
            fails++;
            wrap_up();
        end
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            fails++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic axi_write(input logic [7:0] a, input logic [31:0] d);
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (s_axi_bvalid !== 1'b1);
        resp_got = s_axi_bresp;
        s_axi_bready <= 1'b0;
    endtask
    task automatic axi_read(input logic [7:0] a);
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (s_axi_rvalid !== 1'b1);
        rdata_got = s_axi_rdata;
        resp_got = s_axi_rresp;
        s_axi_rready <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        axi_read(a);
        chk(rdata_got, e);
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        axi_write(a, d);
        chk(resp_got, LPW_RESP_OKAY);
    endtask
    task automatic sleep();
        @(posedge aclk);
        sleep_req <= 1'b1;
        @(posedge aclk);
        sleep_req <= 1'b0;
    endtask
    // Pin edges need two sync stages, a compare and the flag stage.
    task automatic settle();
        repeat (6) @(posedge aclk);
    endtask
    task automatic wait_wake();
        for (int n = 0; n < 20 && in_low_power_mode === 1'b1; n++) @(posedge aclk);
        chk(in_low_power_mode, 1'b0);
    endtask
    task automatic wrap_up();
        $display("Checks %0d, mismatches %0d", checked, fails);
        if (fails == 0 && checked > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    // --------
    // Sequence
    // --------
    initial begin
        repeat (3) @(posedge aclk);
        aresetn <= 1'b1;
        foreach (rows[i]) begin
            if (rows[i].wr) begin
                axi_write(rows[i].addr, rows[i].data);
                chk(resp_got, rows[i].resp);
            end
            axi_read(rows[i].addr);
            chk(rdata_got, rows[i].exp);
            chk(resp_got, rows[i].resp);
            chk(outs, rows[i].outs);
        end
        sleep();
        model.flip(0, 5);
        settle();
        chk(in_low_power_mode, 1'b1);
        chk(wake_irq, 1'b0);
        rd(8'h04, 32'h20);
        wr(8'h44, 32'h1);
        chk(global_gpio_wake_enable, 1'b1);
        wait_wake();
        chk(wake_irq, 1'b1);
        wr(8'h04, 32'h0);
        rd(8'h04, 32'h20);
        wr(8'h04, 32'h20);
        rd(8'h04, 32'h0);
        chk(wake_irq, 1'b0);
        wr(8'h08, 32'h0);
        wr(8'h10, 32'hffff_fc00);
        sleep();
        model.flip(1, 9);
        settle();
        chk(in_low_power_mode, 1'b1);
        rd(8'h0c, 32'h200);
        model.flip(3, 1);
        wait_wake();
        rd(8'h1c, 32'h2);
        model.flip(0, 0);
        model.flip(2, 7);
        @(posedge aclk);
        periph_wake_event <= 32'h10;
        @(posedge aclk);
        periph_wake_event <= 32'h0;
        settle();
        rd(8'h14, 32'h80);
        rd(8'h30, 32'h10);
        chk(wake_irq, 1'b1);
        wr(8'h00, 32'h8000_0900);
        foreach (clr_list[i]) rd(clr_list[i], 32'h0);
        rd(8'h00, 32'h0000_0900);
        chk(wake_irq, 1'b0);
        // Mid-run reset with pins held high: no false edge on ports 0 and 3, and control, its outputs and the global enable back at reset values.
        wr(8'h00, 32'h0000_0005);
        chk(outs, 7'h05);
        @(posedge aclk);
        aresetn <= 1'b0;
        repeat (3) @(posedge aclk);
        aresetn <= 1'b1;
        chk(outs, 7'h50);
        chk(global_gpio_wake_enable, 1'b0);
        settle();
        rd(8'h04, 32'h0);
        rd(8'h1c, 32'h0);
        rd(8'h00, 32'h0000_0900);
        wrap_up();
    end
endmodule // tb
